/* File: bench/core_model.sv */
// core-side model: byte accesses to the accumulator byte port
// assumes the bench calls its tasks from one process, one access at a time
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic sys_clk,
    // register access
    output math_acc_pkg::sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata
);
    initial sfr_req = '0;

    // strobe held through its taking edge, read data taken at that edge
    task automatic access(input logic [7:0] addr, input logic rd, input logic wr,
                          input logic [7:0] wdata, output logic [7:0] rdata);
        @(posedge sys_clk);
        sfr_req <= '{addr: addr, rd: rd, wr: wr, wdata: wdata};
        @(posedge sys_clk);
        // released lines show the inverse, so stale values never look valid
        sfr_req <= '{addr: ~addr, rd: 1'b0, wr: 1'b0, wdata: ~wdata};
        #1;
        rdata = sfr_rdata;
    endtask

    // narrow loads use fewer writes, upper bytes must already be zero
    task automatic load(input logic [39:0] value, input int nbytes);
        logic [7:0] d;
        for (int i = 0; i < nbytes; i++) begin
            access(math_acc_pkg::ACC_PORT_ADDR, 1'b0, 1'b1, value[8*i+:8], d);
        end
    endtask
endmodule

/* File: bench/math_accumulator_byte_port_tb.sv */
// self-checking bench for the accumulator byte port
// assumes core_model drives the register side; bench drives completions and controls
`timescale 1ns/1ps
module math_accumulator_byte_port_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    math_acc_pkg::sfr_req_type sfr_req;
    math_acc_pkg::calc_event_type calc = '0;
    math_acc_pkg::ctl_pulse_type ctl = '0;
    logic [7:0] sfr_rdata;
    logic [39:0] acc_value;
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [7:0] b;
    logic [39:0] e;
    int n_fail = 0;
    int tests_run = 0;

    always #2.5 sys_clk = ~sys_clk;

    math_accumulator_byte_port dut_u (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .calc(calc), .ctl(ctl), .acc_value(acc_value), .rd_ptr(rd_ptr),
        .wr_ptr(wr_ptr));
    core_model core_u (.sys_clk(sys_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wrb(input logic [7:0] v);
        logic [7:0] d;
        core_u.access(math_acc_pkg::ACC_PORT_ADDR, 1'b0, 1'b1, v, d);
    endtask

    task automatic rdb(output logic [7:0] v);
        core_u.access(math_acc_pkg::ACC_PORT_ADDR, 1'b1, 1'b0, 8'h00, v);
    endtask

    task automatic pulse(input math_acc_pkg::ctl_pulse_type c);
        @(posedge sys_clk);
        ctl <= c;
        @(posedge sys_clk);
        ctl <= '0;
        #1;
    endtask

    task automatic t_reset;
        chk(acc_value, 40'h00_0000_0000);
        chk({sfr_rdata, rd_ptr, wr_ptr}, {8'h00, 3'h4, 3'h0});
    endtask

    // full load, locked write pointer, stray address, full read and overread
    task automatic t_write_read;
        for (int i = 0; i < 5; i++) begin
            wrb(8'(8'h11 * (i + 1)));
            chk(wr_ptr, (i < 4) ? i + 1 : 4);
        end
        chk(acc_value, 40'h55_4433_2211);
        wrb(8'h66);
        chk({acc_value, wr_ptr}, {40'h66_4433_2211, 3'h4});
        core_u.access(8'hd4, 1'b0, 1'b1, 8'h99, b);
        chk(acc_value, 40'h66_4433_2211);
        core_u.access(8'hd4, 1'b1, 1'b0, 8'h00, b);
        chk({rd_ptr, sfr_rdata}, {3'h4, 8'h00});
        e = 40'h66_4433_2211;
        for (int i = 0; i < 7; i++) begin
            rdb(b);
            chk(b, (i < 5) ? e[8*(4-i)+:8] : e[7:0]);
            chk(rd_ptr, (i < 4) ? 3 - i : 0);
        end
        chk(acc_value, e);
    endtask

    // every operation kind, including a carry out of bit 39
    task automatic t_calc;
        math_acc_pkg::calc_op_type ops [5] = '{math_acc_pkg::OP_MULTIPLY, math_acc_pkg::OP_DIVIDE,
            math_acc_pkg::OP_SHIFT, math_acc_pkg::OP_NORMALIZE, math_acc_pkg::OP_MULTIPLY};
        logic [39:0] res [5] = '{40'h01_0000_0001, 40'h00_0000_0100, 40'h77_7777_7777,
            40'h12_3456_789a, 40'hff_ffff_ffff};
        e = 40'h66_4433_2211;
        for (int i = 0; i < 5; i++) begin
            rdb(b);
            wrb(8'h66);
            // write pointer rests on byte 4 only after the full load before this task
            if (i == 0) begin
                e[39:32] = 8'h66;
            end else begin
                e[7:0] = 8'h66;
            end
            chk(acc_value, e);
            @(posedge sys_clk);
            calc <= '{done: 1'b1, op: ops[i], result: res[i]};
            @(posedge sys_clk);
            calc <= '0;
            #1;
            e = (i == 2 || i == 3) ? e : 40'(e + res[i]);
            chk(acc_value, e);
            chk({rd_ptr, wr_ptr}, {3'h4, 3'h0});
        end
    endtask

    // clear bit, pointer reinit events, five zero writes, narrow loads
    task automatic t_clear;
        wrb(8'h5a);
        pulse('{clear_accumulator_ctl: 1'b1, default: 1'b0});
        chk({acc_value, wr_ptr}, {40'h00_0000_0000, 3'h1});
        for (int i = 0; i < 2; i++) begin
            rdb(b);
            wrb(8'h01);
            pulse(i == 0 ? 3'b010 : 3'b001);
            chk({rd_ptr, wr_ptr}, {3'h4, 3'h0});
        end
        core_u.load(40'h9a_bcde_f012, 5);
        for (int i = 0; i < 5; i++) begin
            wrb(8'h00);
            chk(acc_value, (i < 4) ? 40'h00_bcde_f012 : 40'h00_0000_0000);
        end
        pulse('{sequence_start_ctl: 1'b1, default: 1'b0});
        core_u.load(40'h00_0000_beef, 2);
        chk(acc_value, 40'h00_0000_beef);
        pulse('{sequence_start_ctl: 1'b1, default: 1'b0});
        core_u.load(40'h00_cafe_f00d, 4);
        chk(acc_value, 40'h00_cafe_f00d);
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_write_read();
        t_calc();
        t_clear();
        report_and_stop();
    end
endmodule

/* File: core/acc_adder.sv */
// forty-bit adder for the accumulator, carry out dropped
// assumes both operands are already forty bits; purely combinational
`timescale 1ns/1ps
module acc_adder (
    // operands
    input wire logic [39:0] acc,
    input wire logic [39:0] addend,
    // truncated sum
    output logic [39:0] sum
);

    logic [40:0] full_sum;

    always_comb begin
        full_sum = {1'b0, acc} + {1'b0, addend};
        // carry out of bit 39 is lost on purpose
        sum = full_sum[39:0];
    end

endmodule

/* File: core/math_acc_pkg.sv */
// constants, carrier structs and helpers for the math accumulator byte port
// assumes one core clock domain; all strobes are single-cycle pulses from core logic
package math_acc_pkg;

    // byte port location in special-function register space
    localparam logic [7:0] ACC_PORT_ADDR = 8'hd5;

    // accumulator geometry
    localparam int ACC_WIDTH = 40;
    localparam int ACC_BYTES = 5;

    // values after reset
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // byte pointer positions, byte 0 is least significant
    localparam logic [2:0] RD_PTR_INIT = 3'h4;
    localparam logic [2:0] RD_PTR_LAST = 3'h0;
    localparam logic [2:0] WR_PTR_INIT = 3'h0;
    localparam logic [2:0] WR_PTR_LAST = 3'h4;
    localparam logic [2:0] PTR_STEP = 3'h1;

    // consecutive zero-byte writes that clear the accumulator
    localparam logic [2:0] ZERO_RUN_RESET = 3'h0;
    localparam logic [2:0] ZERO_RUN_LAST = 3'h4;

    // operation kinds reported at calculation completion
    typedef enum logic [1:0] {
        OP_MULTIPLY,
        OP_DIVIDE,
        OP_SHIFT,
        OP_NORMALIZE
    } calc_op_type;

    // byte access from the core to the register space
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } sfr_req_type;

    // completion report from the arithmetic unit
    typedef struct packed {
        logic done;
        calc_op_type op;
        logic [39:0] result;
    } calc_event_type;

    // control bits written by software elsewhere, seen here as set pulses
    typedef struct packed {
        logic clear_accumulator_ctl;
        logic clear_accelerator_ctl;
        logic sequence_start_ctl;
    } ctl_pulse_type;

    // whole state of the accumulator block
    typedef struct packed {
        logic [39:0] acc;
        logic [2:0] rd_ptr;
        logic [2:0] wr_ptr;
        logic [2:0] zero_run;
        logic [7:0] rdata;
    } acc_state_type;

    // one byte lane of the accumulator
    function automatic logic [7:0] byte_of(input logic [39:0] value, input logic [2:0] idx);
        logic [7:0] lane;
        lane = 8'h00;
        case (idx)
            3'h0: lane = value[7:0];
            3'h1: lane = value[15:8];
            3'h2: lane = value[23:16];
            3'h3: lane = value[31:24];
            3'h4: lane = value[39:32];
            default: lane = 8'h00;
        endcase
        return lane;
    endfunction

    // replace one byte lane of the accumulator
    function automatic logic [39:0] put_byte(input logic [39:0] value, input logic [2:0] idx,
                                             input logic [7:0] lane);
        logic [39:0] res;
        res = value;
        case (idx)
            3'h0: res[7:0] = lane;
            3'h1: res[15:8] = lane;
            3'h2: res[23:16] = lane;
            3'h3: res[31:24] = lane;
            3'h4: res[39:32] = lane;
            default: res = value;
        endcase
        return res;
    endfunction

    // only multiply and divide results accumulate
    function automatic logic accumulates(input calc_op_type op);
        return (op == OP_MULTIPLY) || (op == OP_DIVIDE);
    endfunction

endpackage

/* File: core/math_accumulator_byte_port.sv */
// forty-bit accumulator of the math accelerator behind one byte register
// assumes the core issues single-cycle byte reads and writes on sys_clk
// and that completion and control pulses come from logic on the same clock
`timescale 1ns/1ps
module math_accumulator_byte_port (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register access from the core
    input wire math_acc_pkg::sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    // arithmetic unit completion
    input wire math_acc_pkg::calc_event_type calc,
    // control bit set pulses
    input wire math_acc_pkg::ctl_pulse_type ctl,
    // visible state
    output logic [39:0] acc_value,
    output logic [2:0] rd_ptr,
    output logic [2:0] wr_ptr
);

    math_acc_pkg::acc_state_type state;
    math_acc_pkg::acc_state_type next_state;

    logic port_read;
    logic port_write;
    logic zero_write;
    logic reinit;
    logic add_result;
    logic [39:0] acc_sum;

    // address, data and event decode
    always_comb begin
        port_read = sfr_req.rd && (sfr_req.addr == math_acc_pkg::ACC_PORT_ADDR);
        port_write = sfr_req.wr && (sfr_req.addr == math_acc_pkg::ACC_PORT_ADDR);
        zero_write = port_write && (sfr_req.wdata == 8'h00);
        reinit = calc.done || ctl.clear_accelerator_ctl || ctl.sequence_start_ctl;
        add_result = calc.done && math_acc_pkg::accumulates(calc.op);
    end

    acc_adder u_adder (
        .acc(state.acc),
        .addend(calc.result),
        .sum(acc_sum)
    );

    always_comb begin
        next_state = state;

        // read data is the lane under the read pointer before it moves;
        // past the end the pointer sits on byte 0
        if (port_read) begin
            next_state.rdata = math_acc_pkg::byte_of(state.acc, state.rd_ptr);
            if (state.rd_ptr != math_acc_pkg::RD_PTR_LAST) begin
                next_state.rd_ptr = state.rd_ptr - math_acc_pkg::PTR_STEP;
            end
            // no wrap at the least significant end
        end

        // accumulate only when software is not loading a byte this cycle;
        // a software write wins because it is the more recent intent
        if (add_result && !port_write) begin
            next_state.acc = acc_sum;
        end

        // byte preload at the write pointer
        if (port_write) begin
            next_state.acc = math_acc_pkg::put_byte(state.acc, state.wr_ptr, sfr_req.wdata);
            if (state.wr_ptr != math_acc_pkg::WR_PTR_LAST) begin
                next_state.wr_ptr = state.wr_ptr + math_acc_pkg::PTR_STEP;
            end
            // locks at the most significant byte
        end

        // run of zero bytes counts writes, not cycles, so reads between
        // writes do not break it
        if (zero_write) begin
            if (state.zero_run == math_acc_pkg::ZERO_RUN_LAST) begin
                next_state.acc = math_acc_pkg::ACC_RESET;
                next_state.zero_run = math_acc_pkg::ZERO_RUN_RESET;
            end else begin
                next_state.zero_run = state.zero_run + math_acc_pkg::PTR_STEP;
            end
        end else if (port_write) begin
            next_state.zero_run = math_acc_pkg::ZERO_RUN_RESET;
        end

        // clear bit has the last word on the accumulator
        if (ctl.clear_accumulator_ctl) begin
            next_state.acc = math_acc_pkg::ACC_RESET;
            next_state.zero_run = math_acc_pkg::ZERO_RUN_RESET;
        end

        // pointer reinit overrides any step in the same cycle
        if (reinit) begin
            next_state.rd_ptr = math_acc_pkg::RD_PTR_INIT;
            next_state.wr_ptr = math_acc_pkg::WR_PTR_INIT;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state.acc <= math_acc_pkg::ACC_RESET;
            state.rd_ptr <= math_acc_pkg::RD_PTR_INIT;
            state.wr_ptr <= math_acc_pkg::WR_PTR_INIT;
            state.zero_run <= math_acc_pkg::ZERO_RUN_RESET;
            state.rdata <= math_acc_pkg::RDATA_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        sfr_rdata = state.rdata;
        acc_value = state.acc;
        rd_ptr = state.rd_ptr;
        wr_ptr = state.wr_ptr;
    end

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (!nrst);

    sequence zero_byte_write;
        zero_write;
    endsequence

    sequence clean_read;
        port_read && !reinit;
    endsequence

    sequence quiet_acc;
        !port_write && !calc.done && !ctl.clear_accumulator_ctl;
    endsequence

    sequence lone_write;
        port_write && !reinit;
    endsequence

    sequence quiet_ptrs;
        !port_read && !port_write && !reinit;
    endsequence

    sequence full_zero_run;
        zero_byte_write ##0 (state.zero_run == math_acc_pkg::ZERO_RUN_LAST);
    endsequence

    read_data_a: assert property (
        port_read |=> sfr_rdata == math_acc_pkg::byte_of($past(state.acc), $past(state.rd_ptr)))
        else $error("read data not taken from read pointer lane");

    read_step_a: assert property (
        clean_read ##0 (state.rd_ptr != math_acc_pkg::RD_PTR_LAST)
        |=> state.rd_ptr == $past(state.rd_ptr) - math_acc_pkg::PTR_STEP)
        else $error("read pointer did not step down");

    write_step_a: assert property (
        port_write && !reinit && (state.wr_ptr != math_acc_pkg::WR_PTR_LAST)
        |=> state.wr_ptr == $past(state.wr_ptr) + math_acc_pkg::PTR_STEP)
        else $error("write pointer did not step up");

    pointer_lock_a: assert property (
        clean_read ##0 (state.rd_ptr == math_acc_pkg::RD_PTR_LAST)
        |=> state.rd_ptr == math_acc_pkg::RD_PTR_LAST)
        else $error("read pointer wrapped");

    write_lock_a: assert property (
        lone_write ##0 (state.wr_ptr == math_acc_pkg::WR_PTR_LAST)
        |=> state.wr_ptr == math_acc_pkg::WR_PTR_LAST)
        else $error("write pointer wrapped");

    pointer_reinit_a: assert property (
        reinit |=> (state.rd_ptr == math_acc_pkg::RD_PTR_INIT) && (state.wr_ptr == math_acc_pkg::WR_PTR_INIT))
        else $error("pointers not reinitialised");

    accumulate_sum_a: assert property (
        add_result && !port_write && !ctl.clear_accumulator_ctl
        |=> state.acc == 40'($past(state.acc) + $past(calc.result)))
        else $error("result not added into accumulator");

    no_shift_add_a: assert property (
        calc.done && !math_acc_pkg::accumulates(calc.op) && !port_write && !ctl.clear_accumulator_ctl
        |=> $stable(state.acc))
        else $error("shift or normalize result changed accumulator");

    read_keeps_acc_a: assert property (
        port_read ##0 quiet_acc |=> $stable(state.acc))
        else $error("read disturbed accumulator");

    clear_bit_a: assert property (
        ctl.clear_accumulator_ctl |=> state.acc == math_acc_pkg::ACC_RESET)
        else $error("clear bit did not clear accumulator");

    zero_run_clear_a: assert property (
        zero_byte_write ##0 (state.zero_run == math_acc_pkg::ZERO_RUN_LAST)
        |=> state.acc == math_acc_pkg::ACC_RESET)
        else $error("five zero writes did not clear accumulator");

    write_lane_a: assert property (
        port_write && !ctl.clear_accumulator_ctl && !(zero_write && state.zero_run == math_acc_pkg::ZERO_RUN_LAST)
        |=> math_acc_pkg::byte_of(state.acc, $past(state.wr_ptr)) == $past(sfr_req.wdata))
        else $error("written byte not stored at write pointer");

    tail_read_a: assert property (
        clean_read ##0 (state.rd_ptr == math_acc_pkg::RD_PTR_LAST) ##1 clean_read
        |=> sfr_rdata == math_acc_pkg::byte_of($past(state.acc), math_acc_pkg::RD_PTR_LAST))
        else $error("read past end not least significant byte");

    tail_hold_a: assert property (
        clean_read ##0 (state.rd_ptr == math_acc_pkg::RD_PTR_LAST)
        |=> sfr_rdata == math_acc_pkg::byte_of($past(state.acc), math_acc_pkg::RD_PTR_LAST))
        else $error("read at last lane not least significant byte");

    ptr_hold_a: assert property (
        quiet_ptrs |=> $stable(state.rd_ptr) && $stable(state.wr_ptr))
        else $error("byte pointer moved with no access");

    ptr_range_a: assert property (
        (state.rd_ptr <= math_acc_pkg::RD_PTR_INIT) && (state.wr_ptr <= math_acc_pkg::WR_PTR_LAST))
        else $error("byte pointer outside five lanes");

    write_keeps_rd_a: assert property (
        lone_write ##0 !port_read |=> $stable(state.rd_ptr))
        else $error("write moved read pointer");

    read_keeps_wr_a: assert property (
        clean_read ##0 !port_write |=> $stable(state.wr_ptr))
        else $error("read moved write pointer");

    stray_write_a: assert property (
        sfr_req.wr && (sfr_req.addr != math_acc_pkg::ACC_PORT_ADDR) && !reinit && !ctl.clear_accumulator_ctl
        |=> $stable(state.wr_ptr) && $stable(state.acc))
        else $error("write to other address reached accumulator");

    stray_read_a: assert property (
        sfr_req.rd && (sfr_req.addr != math_acc_pkg::ACC_PORT_ADDR) && !reinit
        |=> $stable(state.rd_ptr) && $stable(sfr_rdata))
        else $error("read of other address moved read side");

    acc_hold_a: assert property (
        quiet_acc |=> $stable(state.acc))
        else $error("accumulator changed with no cause");

    rdata_hold_a: assert property (
        !port_read |=> $stable(sfr_rdata))
        else $error("read data changed with no read");

    write_whole_a: assert property (
        port_write && !ctl.clear_accumulator_ctl
        && !(zero_write && (state.zero_run == math_acc_pkg::ZERO_RUN_LAST))
        |=> state.acc == math_acc_pkg::put_byte($past(state.acc), $past(state.wr_ptr), $past(sfr_req.wdata)))
        else $error("byte write disturbed other lanes");

    zero_run_step_a: assert property (
        zero_byte_write ##0 (state.zero_run != math_acc_pkg::ZERO_RUN_LAST) ##0 !ctl.clear_accumulator_ctl
        |=> state.zero_run == $past(state.zero_run) + math_acc_pkg::PTR_STEP)
        else $error("zero run did not count");

    zero_run_wrap_a: assert property (
        full_zero_run |=> state.zero_run == math_acc_pkg::ZERO_RUN_RESET)
        else $error("zero run did not restart after clearing");

    zero_run_break_a: assert property (
        port_write && !zero_write |=> state.zero_run == math_acc_pkg::ZERO_RUN_RESET)
        else $error("nonzero write did not break zero run");

    clear_run_a: assert property (
        ctl.clear_accumulator_ctl |=> state.zero_run == math_acc_pkg::ZERO_RUN_RESET)
        else $error("clear bit did not restart zero run");

    run_keeps_a: assert property (
        !port_write && !ctl.clear_accumulator_ctl |=> $stable(state.zero_run))
        else $error("zero run moved without a write");

    zero_run_range_a: assert property (
        state.zero_run <= math_acc_pkg::ZERO_RUN_LAST)
        else $error("zero run past five writes");

    carry_drop_a: assert property (
        add_result && !port_write && !ctl.clear_accumulator_ctl
        && (40'(state.acc + calc.result) < state.acc)
        |=> state.acc < $past(state.acc))
        else $error("carry out of bit 39 kept");

endmodule
